// ===== logic/dar_pkg.sv
// constants and types shared by the dual converter readout block
package dar_pkg;
    localparam int unsigned RES_W       = 12;      // result width
    localparam int unsigned CNT_W       = 6;       // falling edge counter width
    localparam logic [11:0] CODE_MIN    = 12'h000; // lowest straight binary code
    localparam logic [11:0] CODE_MAX    = 12'hfff; // highest code, 4095 of 4096 steps
    localparam logic [5:0]  EDGE_GUARD  = 6'h02;   // below this a release is a glitch
    localparam logic [5:0]  EDGE_AWAKE  = 6'h0a;   // from here on the part stays powered
    localparam logic [5:0]  EDGE_RESULT = 6'h0e;   // edges for one complete result
    localparam logic [5:0]  EDGE_LAST   = 6'h20;   // edge that ends the dual read
    localparam logic [5:0]  CNT_FIRST   = 6'h01;   // count after the first edge of a frame
    localparam logic [5:0]  CNT_RST     = 6'h00;   // counter value after reset
    localparam logic [3:0]  SLOT_LEAD   = 4'h2;    // leading zeros in each 16 edge slot
    localparam logic [3:0]  SLOT_MSB    = 4'hd;    // slot position of the msb plus msb index
    localparam logic [11:0] WORD_RST    = 12'h000; // result word after reset
    localparam logic        TOGGLE_RST  = 1'b0;    // handshake toggles after reset

    // power state of the converter pair
    typedef enum logic [1:0] {
        PM_NORMAL  = 2'b00,
        PM_PARTIAL = 2'b01,
        PM_FULL    = 2'b10
    } dar_pm_t;

    localparam dar_pm_t PM_RST = PM_NORMAL;       // power state after reset
endpackage : dar_pkg

// ===== logic/dar_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module dar_sync
    import dar_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_r;
    logic sync_r;

    // first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;
endmodule : dar_sync

// ===== logic/dar_readout.sv
// serial readout and power mode control of the dual converter
`timescale 1ns/10ps
module dar_readout
    import dar_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic [RES_W-1:0]  result_a_in,
    input  wire logic [RES_W-1:0]  result_b_in,
    input  wire logic              result_valid_in,
    output logic                   result_ready_out,
    output logic                   partial_down_out,
    output logic                   full_down_out,
    input  wire logic              sclk_in,
    input  wire logic              cs_n_in,
    output logic                   serial_out_first_out,
    output logic                   serial_out_first_oe_out,
    output logic                   serial_out_second_out,
    output logic                   serial_out_second_oe_out
);
    // ---------------- system clock side ----------------
    logic [RES_W-1:0] pub_a_r;
    logic [RES_W-1:0] pub_b_r;
    logic             req_r;
    logic             ack_sys;
    logic             part_sys;
    logic             full_sys;
    logic             link_rst;
    logic             take_word;

    // a new pair is published only when the link has taken the last one
    assign result_ready_out = (req_r == ack_sys);
    assign take_word        = result_valid_in & result_ready_out;

    // publish register, held stable while the request is outstanding
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pub_a_r <= WORD_RST;
            pub_b_r <= WORD_RST;
            req_r   <= TOGGLE_RST;
        end else if (take_word) begin
            pub_a_r <= result_a_in;
            pub_b_r <= result_b_in;
            req_r   <= ~req_r;
        end
    end

    // ---------------- crossings ----------------
    localparam logic [1:0] PM_SHOW_RST = {PM_RST == PM_PARTIAL, PM_RST == PM_FULL};
    logic             ack_r;
    logic             req_link;
    dar_pm_t          mode_r;
    dar_pm_t          mode_nxt;
    logic [2:0]       to_sys;
    logic [2:0]       at_sys;
    logic [1:0]       pm_seen_r;
    logic [1:0]       pm_show_r;

    // power state as it stands now: a release point counts as soon as select rises,
    // so a host that stops the clock after the release still sees the new state
    assign to_sys = {ack_r, (mode_nxt == PM_PARTIAL), (mode_nxt == PM_FULL)};

    // link state levels into the system domain
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_to_sys
            dar_sync u_sync (
                .clk_in (sys_clk_in),
                .rst_in (sys_rst_in),
                .d_in   (to_sys[gi]),
                .q_out  (at_sys[gi])
            );
        end
    endgenerate

    assign ack_sys = at_sys[2];

    // the pair of state bits is shown only once two samples agree, so a step that
    // flips both bits never shows a mixed state
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pm_seen_r <= PM_SHOW_RST;
            pm_show_r <= PM_SHOW_RST;
        end else begin
            pm_seen_r <= at_sys[1:0];
            if (pm_seen_r == at_sys[1:0]) begin
                pm_show_r <= pm_seen_r;
            end
        end
    end

    // state flags come straight from the filter flops
    assign partial_down_out = pm_show_r[1];
    assign full_down_out    = pm_show_r[0];

    // request toggle into the link domain
    dar_sync u_req_sync (
        .clk_in (sclk_in),
        .rst_in (link_rst),
        .d_in   (req_r),
        .q_out  (req_link)
    );

    // reset into the link domain
    dar_sync u_rst_sync (
        .clk_in (sclk_in),
        .rst_in (1'b0),
        .d_in   (sys_rst_in),
        .q_out  (link_rst)
    );

    // ---------------- serial clock side ----------------
    logic             open_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [RES_W-1:0] word_a_r;
    logic [RES_W-1:0] word_b_r;
    logic [RES_W-1:0] word_a_nxt;
    logic [RES_W-1:0] word_b_nxt;
    logic             fresh;
    logic             drive_r;
    logic             drive_nxt;
    logic             sa_r;
    logic             sb_r;
    logic             sa_nxt;
    logic             sb_nxt;

    // bit shown after falling edge k: two zeros, twelve bits msb first, two zeros
    function automatic logic bit_at(input logic [CNT_W-1:0] k,
                                    input logic [RES_W-1:0] w_own,
                                    input logic [RES_W-1:0] w_other);
        logic [RES_W-1:0] w;
        logic [3:0]       p;
        w = k[4] ? w_other : w_own;
        p = k[3:0];
        if (k >= EDGE_LAST)
            bit_at = 1'b0;
        else if ((p >= SLOT_LEAD) && (p <= SLOT_MSB))
            bit_at = w[SLOT_MSB - p];
        else
            bit_at = 1'b0;
    endfunction : bit_at

    // power state from the previous frame's release point
    function automatic dar_pm_t mode_after(input dar_pm_t m, input logic [CNT_W-1:0] c);
        if (c < EDGE_GUARD)
            mode_after = m;
        else if (c < EDGE_AWAKE)
            mode_after = (m == PM_NORMAL) ? PM_PARTIAL : PM_FULL;
        else
            mode_after = PM_NORMAL;
    endfunction : mode_after

    // next edge count, saturating at the end of the dual read
    assign cnt_nxt = !open_r ? CNT_FIRST :
                     (cnt_r == EDGE_LAST) ? cnt_r : cnt_r + CNT_FIRST;
    assign fresh      = !open_r && (req_link != ack_r);
    assign word_a_nxt = fresh ? pub_a_r : word_a_r;
    assign word_b_nxt = fresh ? pub_b_r : word_b_r;
    assign mode_nxt   = !open_r ? mode_after(mode_r, cnt_r) : mode_r;
    assign drive_nxt  = (cnt_nxt < EDGE_LAST);
    assign sa_nxt     = bit_at(cnt_nxt, word_a_nxt, word_b_nxt);
    assign sb_nxt     = bit_at(cnt_nxt, word_b_nxt, word_a_nxt);

    // frame marker, cleared at once while select is high
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in)
            open_r <= 1'b0;
        else
            open_r <= 1'b1;
    end

    // output bits and drive window, reset by select so each frame opens with a zero
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            sa_r    <= 1'b0;
            sb_r    <= 1'b0;
            drive_r <= 1'b1;
        end else begin
            sa_r    <= sa_nxt;
            sb_r    <= sb_nxt;
            drive_r <= drive_nxt;
        end
    end

    // edge counter, power state and result words
    always_ff @(negedge sclk_in) begin
        if (link_rst) begin
            cnt_r    <= CNT_RST;
            mode_r   <= PM_RST;
            word_a_r <= WORD_RST;
            word_b_r <= WORD_RST;
            ack_r    <= TOGGLE_RST;
        end else begin
            cnt_r    <= cnt_nxt;
            mode_r   <= mode_nxt;
            word_a_r <= word_a_nxt;
            word_b_r <= word_b_nxt;
            ack_r    <= fresh ? req_link : ack_r;
        end
    end

    // drive only inside the frame window; release floats the lines at once
    assign serial_out_first_out     = sa_r;
    assign serial_out_second_out    = sb_r;
    assign serial_out_first_oe_out  = ~cs_n_in & drive_r;
    assign serial_out_second_oe_out = ~cs_n_in & drive_r;
endmodule : dar_readout

// ===== testbench/dar_readout_chk.sv
// port assertions for the dual converter readout
`timescale 1ns/10ps
module dar_readout_chk
    import dar_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic result_valid_in,
    input wire logic result_ready_out,
    input wire logic partial_down_out,
    input wire logic full_down_out,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic serial_out_first_out,
    input wire logic serial_out_first_oe_out,
    input wire logic serial_out_second_out,
    input wire logic serial_out_second_oe_out
);
    logic [5:0] cnt_r;
    // falling edges seen in the open frame
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) cnt_r <= CNT_RST;
        else if (cnt_r != 6'h3f) cnt_r <= cnt_r + 6'h01;
    end
    // handshake and framing steps
    sequence s_taken; result_valid_in && result_ready_out; endsequence
    sequence s_quiet; !serial_out_first_oe_out && !serial_out_second_oe_out; endsequence
    a_ready_drop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_taken |=> !result_ready_out) else $error("ready held after take");
    a_float_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cs_n_in |-> s_quiet) else $error("line driven while deselected");
    a_float_last: assert property (@(posedge sclk_in) disable iff (sys_rst_in)
        cnt_r >= EDGE_LAST |-> s_quiet) else $error("line driven after last edge");
    a_drive_frame: assert property (@(posedge sclk_in) disable iff (sys_rst_in)
        !cs_n_in && cnt_r < EDGE_LAST |-> serial_out_first_oe_out && serial_out_second_oe_out)
        else $error("line floated inside frame");
    a_lead_zero: assert property (@(posedge sclk_in) disable iff (sys_rst_in)
        !cs_n_in && cnt_r < EDGE_GUARD |-> !serial_out_first_out && !serial_out_second_out)
        else $error("leading bit not zero");
    a_trail_zero: assert property (@(posedge sclk_in) disable iff (sys_rst_in)
        !cs_n_in && cnt_r inside {[14:17], 30, 31}
        |-> !serial_out_first_out && !serial_out_second_out) else $error("trailing bit not zero");
    a_full_entry: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(full_down_out) |-> $past(partial_down_out, 2)) else $error("full without partial");
endmodule : dar_readout_chk

bind dar_readout dar_readout_chk chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .result_valid_in(result_valid_in), .result_ready_out(result_ready_out),
    .partial_down_out(partial_down_out), .full_down_out(full_down_out), .sclk_in(sclk_in),
    .cs_n_in(cs_n_in), .serial_out_first_out(serial_out_first_out),
    .serial_out_first_oe_out(serial_out_first_oe_out),
    .serial_out_second_out(serial_out_second_out),
    .serial_out_second_oe_out(serial_out_second_oe_out));

// ===== testbench/dar_host.sv
// host model driving select and serial clock
`timescale 1ns/10ps
module dar_host (
    input wire logic free_in,
    input wire logic line_a_in,
    input wire logic line_b_in,
    output logic     sclk_out,
    output logic     cs_n_out
);
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
    end
    // clock runs free only while the link side comes out of reset
    always #6 if (free_in) sclk_out = ~sclk_out;
    // frame of n falling edges, bit k of each line lands at index 32-k
    task automatic frame(input int n, output logic [32:0] a, output logic [32:0] b);
        a = '1;
        b = '1;
        sclk_out = 1'b1;
        #6 cs_n_out = 1'b0;
        #6;
        for (int k = 0; k <= n; k++) begin
            a[32-k] = line_a_in;
            b[32-k] = line_b_in;
            if (k < n) begin
                sclk_out = 1'b0;
                #6 sclk_out = 1'b1;
                #6;
            end
        end
        cs_n_out = 1'b1;
        #6;
    endtask : frame
endmodule : dar_host

// ===== testbench/tb_dual_adc_serial_readout_modes.sv
// self-checking bench for the dual converter readout
`timescale 1ns/10ps
module tb_dual_adc_serial_readout_modes;
    import dar_pkg::*;
    logic             clk = 1'b0, rst = 1'b1, valid = 1'b0, free = 1'b1;
    logic             ready, part, full, sclk, cs_n, d_a, oe_a, d_b, oe_b;
    logic [RES_W-1:0] res_a = '0, res_b = '0;
    logic [32:0]      cap_a, cap_b;
    int               err_total = 0, n_tests = 0;
    wire              line_a = oe_a ? d_a : 1'bz;
    wire              line_b = oe_b ? d_b : 1'bz;

    dar_readout DUT (.sys_clk_in(clk), .sys_rst_in(rst), .result_a_in(res_a),
        .result_b_in(res_b), .result_valid_in(valid), .result_ready_out(ready),
        .partial_down_out(part), .full_down_out(full), .sclk_in(sclk), .cs_n_in(cs_n),
        .serial_out_first_out(d_a), .serial_out_first_oe_out(oe_a),
        .serial_out_second_out(d_b), .serial_out_second_oe_out(oe_b));
    dar_host host (.free_in(free), .line_a_in(line_a), .line_b_in(line_b),
        .sclk_out(sclk), .cs_n_out(cs_n));

    always #20 clk = ~clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    // hand a pair over, then read both results on both lines
    task automatic t_read(input logic [11:0] a, input logic [11:0] b);
        @(negedge clk);
        for (int k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clk);
        check(ready, 1'b1);
        valid = 1'b1;
        res_a = a;
        res_b = b;
        @(negedge clk) valid = 1'b0;
        host.frame(32, cap_a, cap_b);
        host.frame(32, cap_a, cap_b);
        check(cap_a, {2'b0, a, 4'b0, b, 2'b0, 1'bz});
        check(cap_b, {2'b0, b, 4'b0, a, 2'b0, 1'bz});
    endtask : t_read

    // release points walk the power states
    task automatic t_modes();
        int         lens [6] = '{5, 1, 5, 1, 12, 32};
        logic [1:0] exp [6]  = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b00, 2'b00};
        for (int i = 0; i < 6; i++) begin
            host.frame(lens[i], cap_a, cap_b);
            check({line_a, line_b}, 2'bzz);
            repeat (6) @(negedge clk);
            check({part, full}, exp[i]);
        end
    endtask : t_modes

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        free = 1'b0;
        t_read(12'ha5c, 12'h3e1);
        t_read(CODE_MAX, CODE_MIN);
        t_modes();
        test_done();
    end

    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule : tb_dual_adc_serial_readout_modes
